// File: core/arcs_defs.svh
// register offsets, field positions, reset values and codes for the retry and swap bank
`ifndef ARCS_DEFS_SVH
`define ARCS_DEFS_SVH

// ==========================================================================
// register byte offsets
`define ARCS_RETRY_OFS      8'h08
`define ARCS_SWAP_VAL_OFS   8'h0C
`define ARCS_CMP_VAL_OFS    8'h10
`define ARCS_SWAP_CTRL_OFS  8'h14
`define ARCS_IRQ_STAT_OFS   8'h24
`define ARCS_IRQ_MASK_OFS   8'h28

// ==========================================================================
// field positions and widths
`define ARCS_RETRY_W        4
`define ARCS_LIMITS_W       12
`define ARCS_DONE_BIT       31
`define ARCS_SEL_W          2
`define ARCS_IRQ_W          4
`define ARCS_IRQ_SWAP_BIT   0
`define ARCS_IRQ_UNIT_LSB   1

// ==========================================================================
// reset values
`define ARCS_LIMITS_RST     12'h000
`define ARCS_DONE_RST       1'b1
`define ARCS_SEL_RST        2'h0
`define ARCS_BM_ID_RST      32'h0000003F
`define ARCS_BW_AVAIL_RST   32'h00001333
`define ARCS_CH_HI_RST      32'hFFFFFFFF
`define ARCS_CH_LO_RST      32'hFFFFFFFF

// ==========================================================================
// acknowledge codes
`define ARCS_ACK_BUSY_X     4'h4
`define ARCS_ACK_BUSY_A     4'h5
`define ARCS_ACK_BUSY_B     4'h6
`define ARCS_ACK_DATA_ERR   4'hD

`endif

// File: core/arcs_pkg.sv
// types shared by the retry and swap register bank
package arcs_pkg;

  typedef enum logic [1:0] {
    ARCS_IDLE = 2'b01,
    ARCS_SWAP = 2'b10
  } arcs_swap_state_e;

  typedef logic [3:0]  arcs_ack_t;
  typedef logic [2:0]  arcs_unit_t;
  typedef logic [11:0] arcs_codes_t;
  typedef logic [31:0] arcs_word_t;

endpackage : arcs_pkg

// File: core/arcs_regs.sv
// retry limit and bus resource compare-swap register bank
//
// Functional notes
// - dual_phase_second_bound field, bits 31-29, always reads zero
// - dual_phase_cycle_bound field, bits 28-16, always reads zero
// - bits 15-12 of the retry register read zero
// - phys_response_retry_count, bits 11-8, writable, resets to zero
// - async_response_retry_count, bits 7-4, writable, resets to zero
// - async_request_retry_count, bits 3-0, writable, resets to zero
// - retransmit only on busy or data error acknowledge, up to limit
// - swap value written into selected resource only when compare matches
// - compare value is checked against selected resource contents
// - swap_complete_flag set when compare-swap ends; resets to one
// - any write to swap control clears swap_complete_flag, except in the cycle a compare-swap ends, where the set wins
// - select 0 manager id, 1 bandwidth, 2 channels hi, 3 channels lo
// - swap control bits 30-2 read zero
//
// Implementation choice: the Wishbone interface to the registers.
`include "arcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module arcs_regs (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire arcs_pkg::arcs_word_t wb_dat_i,
  output wire arcs_pkg::arcs_word_t wb_dat_o,
  output wire logic               wb_ack_o,
  // transmit units: 0 request, 1 response, 2 physical response
  input  wire arcs_pkg::arcs_unit_t  tx_start_i,
  input  wire arcs_pkg::arcs_unit_t  tx_ack_valid_i,
  input  wire arcs_pkg::arcs_codes_t tx_ack_code_i,
  output wire arcs_pkg::arcs_unit_t  tx_retry_o,
  output wire arcs_pkg::arcs_unit_t  tx_final_o,
  output wire arcs_pkg::arcs_codes_t tx_final_code_o,
  // interrupt
  output wire logic               irq_o
);
  import arcs_pkg::*;

  // ==========================================================================
  // bus handshake
  logic                    ack_q;
  arcs_word_t              dat_q;
  arcs_word_t              rd_d;
  logic                    bus_req;
  logic                    bus_wr;
  arcs_word_t              byte_mask;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr  = bus_req & wb_we_i;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_q <= 32'h00000000;
    end
    else if (bus_req)
    begin
      dat_q <= wb_we_i ? 32'h00000000 : rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  function automatic arcs_word_t merge(input arcs_word_t old_v,
                                       input arcs_word_t new_v,
                                       input arcs_word_t m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // ==========================================================================
  // write strobes
  logic wr_retry;
  logic wr_swap_val;
  logic wr_cmp_val;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  assign wr_retry    = bus_wr & (wb_adr_i == `ARCS_RETRY_OFS);
  assign wr_swap_val = bus_wr & (wb_adr_i == `ARCS_SWAP_VAL_OFS);
  assign wr_cmp_val  = bus_wr & (wb_adr_i == `ARCS_CMP_VAL_OFS);
  assign wr_ctrl     = bus_wr & (wb_adr_i == `ARCS_SWAP_CTRL_OFS);
  assign wr_stat     = bus_wr & (wb_adr_i == `ARCS_IRQ_STAT_OFS);
  assign wr_mask     = bus_wr & (wb_adr_i == `ARCS_IRQ_MASK_OFS);

  // ==========================================================================
  // retry limits
  logic [`ARCS_LIMITS_W-1:0] limits_q;
  arcs_word_t                limits_new;

  assign limits_new = merge({20'h00000, limits_q}, wb_dat_i, byte_mask);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      limits_q <= `ARCS_LIMITS_RST;
    end
    else if (wr_retry)
    begin
      limits_q <= limits_new[`ARCS_LIMITS_W-1:0];
    end
  end

  // ==========================================================================
  // compare and swap values
  arcs_word_t swap_val_q;
  arcs_word_t cmp_val_q;
  arcs_word_t res_old;
  logic       swap_fire;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmp_val_q <= 32'h00000000;
    end
    else if (wr_cmp_val)
    begin
      cmp_val_q <= merge(cmp_val_q, wb_dat_i, byte_mask);
    end
  end

  // swap value returns the old resource contents after the operation
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      swap_val_q <= 32'h00000000;
    end
    else if (swap_fire)
    begin
      swap_val_q <= res_old;
    end
    else if (wr_swap_val)
    begin
      swap_val_q <= merge(swap_val_q, wb_dat_i, byte_mask);
    end
  end

  // ==========================================================================
  // swap control and sequencer
  arcs_swap_state_e          state_q;
  logic                      done_q;
  logic [`ARCS_SEL_W-1:0]    sel_q;

  assign swap_fire = (state_q == ARCS_SWAP);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_q <= `ARCS_SEL_RST;
    end
    else if (wr_ctrl && wb_sel_i[0])
    begin
      sel_q <= wb_dat_i[`ARCS_SEL_W-1:0];
    end
  end

  // writing the select starts the operation
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ARCS_IDLE;
    end
    else
    begin
      case (state_q)
        ARCS_IDLE:
        begin
          if (wr_ctrl)
          begin
            state_q <= ARCS_SWAP;
          end
        end
        ARCS_SWAP:
        begin
          state_q <= wr_ctrl ? ARCS_SWAP : ARCS_IDLE;
        end
        default:
        begin
          state_q <= ARCS_IDLE;
        end
      endcase
    end
  end

  // completion sets, any write clears; set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_q <= `ARCS_DONE_RST;
    end
    else if (swap_fire)
    begin
      done_q <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      done_q <= 1'b0;
    end
  end

  // ==========================================================================
  // bus management resources, reachable only by compare-swap
  arcs_word_t res_q [0:3];

  assign res_old = res_q[sel_q];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_q[0] <= `ARCS_BM_ID_RST;
      res_q[1] <= `ARCS_BW_AVAIL_RST;
      res_q[2] <= `ARCS_CH_HI_RST;
      res_q[3] <= `ARCS_CH_LO_RST;
    end
    else if (swap_fire && (res_old == cmp_val_q))
    begin
      res_q[sel_q] <= swap_val_q;
    end
  end

  // ==========================================================================
  // transmit retry units
  arcs_unit_t unit_fail;

  for (genvar u = 0; u < 3; u++)
  begin : g_unit
    logic [`ARCS_RETRY_W-1:0] cnt_q;
    logic [`ARCS_RETRY_W-1:0] lim;
    arcs_ack_t                code;
    logic                     retryable;
    logic                     again;
    logic                     retry_q;
    logic                     final_q;
    arcs_ack_t                final_code_q;

    assign lim  = limits_q[u*`ARCS_RETRY_W +: `ARCS_RETRY_W];
    assign code = tx_ack_code_i[u*4 +: 4];
    assign retryable = (code == `ARCS_ACK_BUSY_X) | (code == `ARCS_ACK_BUSY_A) |
                       (code == `ARCS_ACK_BUSY_B) | (code == `ARCS_ACK_DATA_ERR);
    assign again = retryable & (cnt_q < lim);

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cnt_q <= 4'h0;
      end
      else if (tx_start_i[u])
      begin
        cnt_q <= 4'h0;
      end
      else if (tx_ack_valid_i[u] && again)
      begin
        cnt_q <= cnt_q + 4'h1;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        retry_q <= 1'b0;
        final_q <= 1'b0;
      end
      else
      begin
        retry_q <= tx_ack_valid_i[u] & again;
        final_q <= tx_ack_valid_i[u] & ~again;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        final_code_q <= 4'h0;
      end
      else if (tx_ack_valid_i[u] && !again)
      begin
        final_code_q <= code;
      end
    end

    assign unit_fail[u] = tx_ack_valid_i[u] & retryable & ~again;
    assign tx_retry_o[u] = retry_q;
    assign tx_final_o[u] = final_q;
    assign tx_final_code_o[u*4 +: 4] = final_code_q;
  end

  // ==========================================================================
  // interrupt status and mask
  logic [`ARCS_IRQ_W-1:0] stat_q;
  logic [`ARCS_IRQ_W-1:0] mask_q;
  logic [`ARCS_IRQ_W-1:0] stat_set;
  logic [`ARCS_IRQ_W-1:0] stat_clr;
  logic                   irq_q;

  assign stat_set = {unit_fail, swap_fire};
  assign stat_clr = wr_stat && wb_sel_i[0] ? wb_dat_i[`ARCS_IRQ_W-1:0] : 4'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_q <= 4'h0;
    end
    else
    begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q <= 4'h0;
    end
    else if (wr_mask && wb_sel_i[0])
    begin
      mask_q <= wb_dat_i[`ARCS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
    end
  end

  assign irq_o = irq_q;

  // ==========================================================================
  // read mux, unmapped addresses read zero
  always_comb
  begin
    rd_d = 32'h00000000;
    case (wb_adr_i)
      `ARCS_RETRY_OFS:
      begin
        rd_d = {3'h0, 13'h0000, 4'h0, limits_q};
      end
      `ARCS_SWAP_VAL_OFS:
      begin
        rd_d = swap_val_q;
      end
      `ARCS_CMP_VAL_OFS:
      begin
        rd_d = cmp_val_q;
      end
      `ARCS_SWAP_CTRL_OFS:
      begin
        rd_d = {done_q, 29'h00000000, sel_q};
      end
      `ARCS_IRQ_STAT_OFS:
      begin
        rd_d = {28'h0000000, stat_q};
      end
      `ARCS_IRQ_MASK_OFS:
      begin
        rd_d = {28'h0000000, mask_q};
      end
      default:
      begin
        rd_d = 32'h00000000;
      end
    endcase
  end

endmodule : arcs_regs
`default_nettype wire

// File: verif/arcs_regs_monitor.sv
// port assertions for the retry and swap register bank
`include "arcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// checker
module arcs_regs_monitor (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // wishbone
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire arcs_pkg::arcs_word_t  wb_dat_i,
  input wire arcs_pkg::arcs_word_t  wb_dat_o,
  input wire logic                  wb_ack_o,
  // transmit units and interrupt
  input wire arcs_pkg::arcs_unit_t  tx_start_i,
  input wire arcs_pkg::arcs_unit_t  tx_ack_valid_i,
  input wire arcs_pkg::arcs_codes_t tx_ack_code_i,
  input wire arcs_pkg::arcs_unit_t  tx_retry_o,
  input wire arcs_pkg::arcs_unit_t  tx_final_o,
  input wire arcs_pkg::arcs_codes_t tx_final_code_o,
  input wire logic                  irq_o
);
  import arcs_pkg::*;
  logic      busy0;
  logic      busy2;
  logic      busy_ack0;
  arcs_ack_t code0;
  assign code0 = tx_ack_code_i[3:0];
  assign busy0 = code0 inside {`ARCS_ACK_BUSY_X, `ARCS_ACK_BUSY_A,
                               `ARCS_ACK_BUSY_B, `ARCS_ACK_DATA_ERR};
  assign busy2 = tx_ack_code_i[11:8] inside {`ARCS_ACK_BUSY_X, `ARCS_ACK_BUSY_A,
                                             `ARCS_ACK_BUSY_B, `ARCS_ACK_DATA_ERR};
  assign busy_ack0 = tx_ack_valid_i[0] && busy0;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_ack_s(logic [7:0] a);
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == a;
  endsequence
  ack_answer_a:
    assert property (wb_req_s |=> wb_ack_o) else $error("request not acked");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  retry_zero_a:
    assert property (rd_ack_s(`ARCS_RETRY_OFS) |-> wb_dat_o[31:12] == 20'h00000)
    else $error("retry upper bits not zero");
  ctrl_zero_a:
    assert property (rd_ack_s(`ARCS_SWAP_CTRL_OFS) |-> wb_dat_o[30:2] == 29'h0)
    else $error("control reserved bits not zero");
  busy_retry_a:
    assert property (tx_retry_o[0] |-> $past(busy_ack0))
    else $error("retry without busy ack");
  final_code_a:
    assert property (tx_final_o[0] |-> $past(tx_ack_valid_i[0]) &&
                     tx_final_code_o[3:0] == $past(code0)) else $error("final code wrong");
  done_final_a:
    assert property (tx_ack_valid_i[2] && !busy2 |=> tx_final_o[2] && !tx_retry_o[2])
    else $error("non busy ack retried");
  code_hold_a:
    assert property (!tx_final_o[1] && !$past(rst_i) |-> $stable(tx_final_code_o[7:4]))
    else $error("final code changed");
endmodule : arcs_regs_monitor
bind arcs_regs arcs_regs_monitor u_arcs_regs_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tx_start_i(tx_start_i), .tx_ack_valid_i(tx_ack_valid_i), .tx_ack_code_i(tx_ack_code_i),
  .tx_retry_o(tx_retry_o), .tx_final_o(tx_final_o), .tx_final_code_o(tx_final_code_o),
  .irq_o(irq_o));
`default_nettype wire

// File: verif/test_arcs_regs.sv
// self-checking bench for the retry and swap register bank
`include "arcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
// ==========================================================================
// bench
module test_arcs_regs;
  import arcs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  arcs_word_t  wb_dat_i = 32'h0;
  arcs_word_t  wb_dat_o, q, nv, cv;
  logic        wb_ack_o, irq_o;
  arcs_unit_t  tx_start_i = 3'h0;
  arcs_unit_t  tx_ack_valid_i = 3'h0;
  arcs_codes_t tx_ack_code_i = 12'h000;
  arcs_unit_t  tx_retry_o, tx_final_o;
  arcs_codes_t tx_final_code_o;
  arcs_word_t  res [4];
  arcs_ack_t   busy [4];
  logic [11:0] lv;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          lim [3];
  always #50 clk_i = ~clk_i;
  arcs_regs u_arcs_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_start_i(tx_start_i),
    .tx_ack_valid_i(tx_ack_valid_i), .tx_ack_code_i(tx_ack_code_i), .tx_retry_o(tx_retry_o),
    .tx_final_o(tx_final_o), .tx_final_code_o(tx_final_code_o), .irq_o(irq_o));
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // expected resource after a compare-swap
  function automatic arcs_word_t nxt(arcs_word_t o, arcs_word_t c, arcs_word_t n);
    return (o === c) ? n : o;
  endfunction : nxt
  task automatic wb(input logic we, input logic [7:0] a, input arcs_word_t d,
                    input logic [3:0] s, output arcs_word_t r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      complete_run();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input arcs_word_t d);
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input arcs_word_t e);
    wb(1'b0, a, 32'h0, 4'hF, q);
    `CHK(q, e)
  endtask : rd
  task automatic go(input int u);
    tx_start_i[u] <= 1'b1;
    @(posedge clk_i);
    tx_start_i[u] <= 1'b0;
    @(posedge clk_i);
  endtask : go
  task automatic ak(input int u, input arcs_ack_t c, input logic r);
    tx_ack_code_i[4*u +: 4] <= c;
    tx_ack_valid_i[u] <= 1'b1;
    @(posedge clk_i);
    tx_ack_valid_i[u] <= 1'b0;
    #1;
    `CHK(tx_retry_o[u], r)
    `CHK(tx_final_o[u], ~r)
    if (!r) `CHK(tx_final_code_o[4*u +: 4], c)
    @(posedge clk_i);
  endtask : ak
  initial
  begin
    void'($urandom(32'hD29A09F4));
    busy = '{`ARCS_ACK_BUSY_X, `ARCS_ACK_BUSY_A, `ARCS_ACK_BUSY_B, `ARCS_ACK_DATA_ERR};
    res = '{`ARCS_BM_ID_RST, `ARCS_BW_AVAIL_RST, `ARCS_CH_HI_RST, `ARCS_CH_LO_RST};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h08, 32'h0);
    rd(8'h14, 32'h80000000);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h00000FFF);
    wr(`ARCS_IRQ_MASK_OFS, 32'hF);
    for (int u = 0; u < 3; u++) lim[u] = $urandom_range(4, 3);
    lv = {4'(lim[2]), 4'(lim[1]), 4'(lim[0])};
    nv = $urandom();
    wr(8'h08, {nv[31:12], lv});
    rd(8'h08, {20'h0, lv});
    wb(1'b1, 8'h08, 32'hFFFFF0FF, 4'h2, q);
    rd(8'h08, {20'h0, 4'h0, lv[7:0]});
    wr(8'h08, {20'h0, lv});
    for (int u = 0; u < 3; u++)
    begin
      go(u);
      for (int k = 0; k < lim[u]; k++) ak(u, busy[k], 1'b1);
      ak(u, busy[lim[u] % 4], 1'b0);
      go(u);
      ak(u, 4'h1, 1'b0);
    end
    for (int s = 0; s < 4; s++)
      for (int i = 0; i < 3; i++)
      begin
        nv = $urandom();
        cv = (i == 0 || $urandom_range(1, 0)) ? res[s] : ~res[s];
        wr(8'h10, cv);
        wr(8'h0C, nv);
        wr(8'h14, {nv[31:2], 2'(s)});
        rd(8'h14, 32'h80000000 | s);
        rd(8'h0C, res[s]);
        res[s] = nxt(res[s], cv, nv);
      end
    `CHK(irq_o, 1'b1)
    rd(`ARCS_IRQ_STAT_OFS, 32'hF);
    wr(`ARCS_IRQ_STAT_OFS, 32'hF);
    rd(`ARCS_IRQ_STAT_OFS, 32'h0);
    `CHK(irq_o, 1'b0)
    wr(8'h08, 32'h0);
    wr(`ARCS_IRQ_MASK_OFS, 32'h0);
    go(0);
    ak(0, busy[3], 1'b0);
    rd(`ARCS_IRQ_STAT_OFS, 32'h2);
    `CHK(irq_o, 1'b0)
    wr(`ARCS_IRQ_MASK_OFS, 32'h2);
    `CHK(irq_o, 1'b1)
    complete_run();
  end
endmodule : test_arcs_regs
`default_nettype wire
